// [sclg_core.sv]
//=====================================================================
// sclg_core.sv - element slots, markers, outputs and apb registers
// assumes: one 10 MHz clock, apb master on the same clock,
// pins on dIn asynchronous, analog codes from same-clock logic
//=====================================================================
`timescale 1ns/1ps
`default_nettype none
`include "sclg_cfg.svh"
module sclg_core #(
   parameter int NUM_SLOTS = `SCLG_MAX_BLOCKS,  // element slots
   parameter int NUM_IN    = 8,                  // digital input pins
   parameter int NUM_OUT   = 4                   // digital output pins
) (
   input  wire logic                  clock,
   input  wire logic                  resetn,
   input  wire sclg_pkg::sclg_apb_req_t apbReq,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic [NUM_IN-1:0]     dIn,
   input  wire logic [9:0]            analogChannelOne,
   input  wire logic [9:0]            analogChannelTwo,
   output logic [NUM_OUT-1:0]         qOut,
   output logic                       scanStrobe
);
   import sclg_pkg::*;

   localparam int SW = $clog2(NUM_SLOTS);
   localparam int SCAN_CYC = `SCLG_SCAN_NS / `SCLG_CLK_NS;
   localparam int NM = `SCLG_NUM_MARKERS;

   //==================================================================
   // state
   //==================================================================
   sclg_slot_t      cfg_r [NUM_SLOTS];     // placed blocks
   sclg_slot_t      cfg_nxt [NUM_SLOTS];
   logic [3:0]      depth_r [NUM_SLOTS];   // blocks in series to here
   logic [3:0]      depth_nxt [NUM_SLOTS];
   logic [6:0]      count_r, count_nxt;     // placed block count
   logic [SW-1:0]   slotSel_r, slotSel_nxt;
   logic [2:0]      ctrl_r, ctrl_nxt;       // run, analog a, analog b
   logic [2:0]      err_r, err_nxt;         // sticky refusal flags
   logic [7:0]      markSrc_r [NM];        // what drives each marker
   logic [7:0]      markSrc_nxt [NM];
   logic [7:0]      outSrc_r [NUM_OUT];
   logic [7:0]      outSrc_nxt [NUM_OUT];
   logic [NM-1:0]   marker_r, marker_nxt;   // marker outputs
   logic            first_r, first_nxt;     // first scan cycle pending
   logic [NUM_SLOTS-1:0] prevAll_r, prevAll_nxt; // all-high last cycle
   logic [NUM_OUT-1:0]   q_r, q_nxt;
   logic [19:0]     anaHold_r, anaHold_nxt; // analog codes of the scan
   logic [15:0]     div_r, div_nxt;         // scan divider
   logic [NUM_IN-1:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;

   // combinational helpers
   logic [NUM_SLOTS-1:0] slotOut;           // element results now
   logic [NM-1:0]   markOut;                // marker view incl startup
   logic [NUM_IN-1:0] inView;               // digital view of pins
   logic            tick;                   // scan strobe
   logic            wrEn, rdEn;
   logic [7:0]      ofs;
   sclg_slot_t      c;
   logic [2:0]      ops;
   logic            allHi, res;

   //==================================================================
   // helpers
   //==================================================================
   // value of a source code; open positions take the gate default
   function automatic logic srcVal(input logic [7:0] code,
                                   input logic dflt,
                                   input logic [NUM_SLOTS-1:0] so);
      logic v;
      v = 1'b0;
      if (code == `SCLG_SRC_OPEN)
         v = dflt;
      else if (code == `SCLG_SRC_ONE)
         v = 1'b1;
      else if (code == `SCLG_SRC_ZERO)
         v = 1'b0;
      else if (code >= `SCLG_SRC_SLOT)
      begin
         if (code - `SCLG_SRC_SLOT < NUM_SLOTS)
            v = so[SW'(code - `SCLG_SRC_SLOT)];
      end
      else if (code >= `SCLG_SRC_MARK)
      begin
         if (code - `SCLG_SRC_MARK < NM)
            v = markOut[3'(code - `SCLG_SRC_MARK)];
      end
      else if (code - `SCLG_SRC_IN < NUM_IN)
         v = inView[3'(code - `SCLG_SRC_IN)];
      return v;
   endfunction : srcVal

   // chain depth fed in by one source; markers and pins restart it
   function automatic logic [3:0] srcDepth(input logic [7:0] code);
      logic [3:0] d;
      d = 4'h0;
      if (code >= `SCLG_SRC_SLOT && code != `SCLG_SRC_OPEN)
      begin
         if (code - `SCLG_SRC_SLOT < NUM_SLOTS)
            d = depth_r[SW'(code - `SCLG_SRC_SLOT)];
      end
      return d;
   endfunction : srcDepth

   // a slot source must name an earlier slot so one pass settles
   function automatic logic badOrder(input logic [7:0] code,
                                     input logic [SW-1:0] idx);
      return code >= `SCLG_SRC_SLOT && code != `SCLG_SRC_OPEN &&
             (code - `SCLG_SRC_SLOT) >= {2'h0, idx};
   endfunction : badOrder

   //==================================================================
   // pin synchroniser: three stages, accept when stages two and three agree
   //==================================================================
   always_comb
   begin
      filt_nxt = filt_r;
      for (int i = 0; i < NUM_IN; i++)
         if (s2_r[i] == s3_r[i])
            filt_nxt[i] = s3_r[i];
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         s1_r   <= '0;
         s2_r   <= '0;
         s3_r   <= '0;
         filt_r <= '0;
      end
      else
      begin
         s1_r   <= dIn;
         s2_r   <= s1_r;
         s3_r   <= s2_r;
         filt_r <= filt_nxt;
      end
   end

   // dual-purpose pins read low as digital while in analog mode
   always_comb
   begin
      inView = filt_r;
      if (ctrl_r[`SCLG_CTRL_ANA_A])
         inView[6] = 1'b0;
      if (ctrl_r[`SCLG_CTRL_ANA_B])
         inView[7] = 1'b0;
   end

   //==================================================================
   // element evaluation, slots in ascending order
   //==================================================================
   assign markOut = {marker_r[NM-1] | first_r, marker_r[NM-2:0]};

   always_comb
   begin
      slotOut     = '0;
      prevAll_nxt = prevAll_r;
      c           = '0;
      ops         = '0;
      allHi       = 1'b0;
      res         = 1'b0;
      for (int i = 0; i < NUM_SLOTS; i++)
      begin
         c = cfg_r[i];
         // open pins: one for and-type gates, zero for or
         ops[0] = srcVal(c.src0, c.gate != GT_OR, slotOut);
         ops[1] = srcVal(c.src1, c.gate != GT_OR, slotOut);
         ops[2] = srcVal(c.src2, c.gate != GT_OR, slotOut);
         allHi  = &ops;
         case (c.gate)
            GT_AND:       res = allHi;
            GT_AND_EDGE:  res = allHi & ~prevAll_r[i];
            GT_NAND:      res = ~allHi;
            GT_NAND_EDGE: res = ~allHi & prevAll_r[i];
            GT_OR:        res = |ops;
            default:      res = 1'b0;
         endcase
         slotOut[i] = c.en & res;
         if (tick)
            prevAll_nxt[i] = allHi;
      end
   end

   //==================================================================
   // scan divider and per-cycle state
   //==================================================================
   assign tick = ctrl_r[`SCLG_CTRL_RUN] && div_r == 16'(SCAN_CYC - 1);

   always_comb
   begin
      div_nxt     = div_r + 16'h1;
      marker_nxt  = marker_r;
      q_nxt       = q_r;
      first_nxt   = first_r;
      anaHold_nxt = anaHold_r;
      if (!ctrl_r[`SCLG_CTRL_RUN])
      begin
         div_nxt   = '0;
         first_nxt = 1'b1;
      end
      else if (tick)
      begin
         div_nxt   = '0;
         first_nxt = 1'b0;
         // markers take their input only at the end of a cycle
         for (int j = 0; j < NM; j++)
            marker_nxt[j] = srcVal(markSrc_r[j], 1'b0, slotOut);
         for (int k = 0; k < NUM_OUT; k++)
            q_nxt[k] = srcVal(outSrc_r[k], 1'b0, slotOut);
         anaHold_nxt = {analogChannelTwo, analogChannelOne};
      end
   end

   //==================================================================
   // apb slave, zero wait states
   //==================================================================
   assign ofs    = apbReq.paddr[7:0];
   assign wrEn   = apbReq.psel & apbReq.penable & apbReq.pwrite;
   assign rdEn   = apbReq.psel & ~apbReq.pwrite;
   assign pready = 1'b1;

   // mapped offsets only; the upper address bits must be zero
   function automatic logic mapped(input logic [11:0] a);
      return a[11:8] == 4'h0 && a[1:0] == 2'b00 &&
             (a[7:0] <= `SCLG_ANALOG_OFS ||
              (a[7:0] >= `SCLG_MARKSRC_OFS &&
               a[7:0] <  `SCLG_MARKSRC_OFS + 8'(4 * NM)) ||
              (a[7:0] >= `SCLG_OUTSRC_OFS &&
               a[7:0] <  `SCLG_OUTSRC_OFS + 8'(4 * NUM_OUT)));
   endfunction : mapped

   assign pslverr = apbReq.psel & apbReq.penable & ~mapped(apbReq.paddr);

   // read mux, combinational from the registers
   always_comb
   begin
      prdata = '0;
      if (ofs == `SCLG_CTRL_OFS)
         prdata = {29'h0, ctrl_r};
      else if (ofs == `SCLG_STATUS_OFS)
         prdata = {17'h0, count_r, 4'h0, markOut[NM-1], err_r};
      else if (ofs == `SCLG_SLOTSEL_OFS)
         prdata = 32'(slotSel_r);
      else if (ofs == `SCLG_SLOTCFG_OFS)
         prdata = cfg_r[slotSel_r];
      else if (ofs == `SCLG_INPUTS_OFS)
         prdata = {12'h0, 4'(q_r), markOut, 8'(inView)};
      else if (ofs == `SCLG_ANALOG_OFS)
         prdata = {12'h0, anaHold_r};
      else if (ofs >= `SCLG_MARKSRC_OFS && ofs < `SCLG_OUTSRC_OFS)
         prdata = {24'h0, markSrc_r[3'(ofs[6:2])]};
      else if (ofs >= `SCLG_OUTSRC_OFS)
         prdata = {24'h0, outSrc_r[2'(ofs[3:2])]};
      if (!rdEn || !mapped(apbReq.paddr))
         prdata = '0;
   end

   //==================================================================
   // register writes and block placement checks
   //==================================================================
   sclg_slot_t newCfg;
   logic [3:0] newDepth, d0, d1, d2;
   logic       fresh;

   always_comb
   begin
      cfg_nxt     = cfg_r;
      depth_nxt   = depth_r;
      count_nxt   = count_r;
      slotSel_nxt = slotSel_r;
      ctrl_nxt    = ctrl_r;
      err_nxt     = err_r;
      markSrc_nxt = markSrc_r;
      outSrc_nxt  = outSrc_r;
      newCfg      = sclg_slot_t'(apbReq.pwdata);
      d0          = srcDepth(newCfg.src0);
      d1          = srcDepth(newCfg.src1);
      d2          = srcDepth(newCfg.src2);
      newDepth    = d0;
      if (d1 > newDepth)
         newDepth = d1;
      if (d2 > newDepth)
         newDepth = d2;
      newDepth    = newDepth + 4'h1;
      fresh       = ~cfg_r[slotSel_r].en;
      if (wrEn && mapped(apbReq.paddr))
      begin
         if (ofs == `SCLG_CTRL_OFS)
            ctrl_nxt = apbReq.pwdata[2:0];
         else if (ofs == `SCLG_STATUS_OFS)
            err_nxt = err_r & ~apbReq.pwdata[2:0];        // write one clears
         else if (ofs == `SCLG_SLOTSEL_OFS)
            slotSel_nxt = SW'(apbReq.pwdata);
         else if (ofs == `SCLG_SLOTCFG_OFS)
         begin
            if (!newCfg.en)
            begin
               if (!fresh)
                  count_nxt = count_r - 7'h1;
               cfg_nxt[slotSel_r] = '0;
               depth_nxt[slotSel_r] = '0;
            end
            else if (fresh && count_r >= 7'(`SCLG_MAX_BLOCKS))
               err_nxt[`SCLG_ST_FULL] = 1'b1;
            else if (newDepth > 4'(`SCLG_MAX_CHAIN))
               err_nxt[`SCLG_ST_CHAIN] = 1'b1;
            else if (badOrder(newCfg.src0, slotSel_r) ||
                     badOrder(newCfg.src1, slotSel_r) ||
                     badOrder(newCfg.src2, slotSel_r))
               err_nxt[`SCLG_ST_ORDER] = 1'b1;
            else
            begin
               cfg_nxt[slotSel_r]   = newCfg;
               depth_nxt[slotSel_r] = newDepth;
               if (fresh)
                  count_nxt = count_r + 7'h1;
            end
         end
         else if (ofs >= `SCLG_MARKSRC_OFS && ofs < `SCLG_OUTSRC_OFS)
            markSrc_nxt[3'(ofs[6:2])] = apbReq.pwdata[7:0];
         else if (ofs >= `SCLG_OUTSRC_OFS)
            outSrc_nxt[2'(ofs[3:2])] = apbReq.pwdata[7:0];
      end
   end

   //==================================================================
   // registers
   //==================================================================
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < NUM_SLOTS; i++)
         begin
            cfg_r[i]   <= '0;
            depth_r[i] <= '0;
         end
         for (int j = 0; j < NM; j++)
            markSrc_r[j] <= `SCLG_SRC_OPEN;
         for (int k = 0; k < NUM_OUT; k++)
            outSrc_r[k] <= `SCLG_SRC_OPEN;
         count_r   <= '0;
         slotSel_r <= '0;
         ctrl_r    <= '0;
         err_r     <= '0;
         marker_r  <= '0;
         first_r   <= 1'b1;
         prevAll_r <= '0;
         q_r       <= '0;
         anaHold_r <= '0;
         div_r     <= '0;
      end
      else
      begin
         cfg_r     <= cfg_nxt;
         depth_r   <= depth_nxt;
         markSrc_r <= markSrc_nxt;
         outSrc_r  <= outSrc_nxt;
         count_r   <= count_nxt;
         slotSel_r <= slotSel_nxt;
         ctrl_r    <= ctrl_nxt;
         err_r     <= err_nxt;
         marker_r  <= marker_nxt;
         first_r   <= first_nxt;
         prevAll_r <= prevAll_nxt;
         q_r       <= q_nxt;
         anaHold_r <= anaHold_nxt;
         div_r     <= div_nxt;
      end
   end

   assign qOut       = q_r;
   assign scanStrobe = tick;

endmodule : sclg_core
`default_nettype wire

// [sclg_cfg.svh]
//=====================================================================
// sclg_cfg.svh - constants of the scan-cycle logic element block
// assumes: included by the package and the core, nothing else
//=====================================================================
// Overview of operation
// - AND high only when all inputs high
// - AND, NAND, edge variants: open pin reads one
// - OR: open pin reads zero
// - edge AND: all high now, some low before
// - NAND low only when all inputs high
// - edge NAND: some low now, all high before
// - OR high when any input high
// - eight markers echo the value written in
// - marker shows last cycle value, stable now
// - startup flag high in first cycle only
// - startup flag later acts as ordinary marker
// - constant one and constant zero sources exist
// - at most 56 blocks, further ones refused
// - series chain over seven blocks refused
// - dual-purpose inputs digital or analog per mode
`ifndef SCLG_CFG_SVH
`define SCLG_CFG_SVH
// register byte offsets
`define SCLG_CTRL_OFS     8'h00
`define SCLG_STATUS_OFS   8'h04
`define SCLG_SLOTSEL_OFS  8'h08
`define SCLG_SLOTCFG_OFS  8'h0c
`define SCLG_INPUTS_OFS   8'h10
`define SCLG_ANALOG_OFS   8'h14
`define SCLG_MARKSRC_OFS  8'h20
`define SCLG_OUTSRC_OFS   8'h40
// field positions
`define SCLG_CTRL_RUN     0
`define SCLG_CTRL_ANA_A   1
`define SCLG_CTRL_ANA_B   2
`define SCLG_ST_FULL      0
`define SCLG_ST_CHAIN     1
`define SCLG_ST_ORDER     2
`define SCLG_ST_START     3
// source codes of an element input
`define SCLG_SRC_ZERO     8'h00
`define SCLG_SRC_ONE      8'h01
`define SCLG_SRC_IN       8'h02
`define SCLG_SRC_MARK     8'h10
`define SCLG_SRC_SLOT     8'h40
`define SCLG_SRC_OPEN     8'hff
// limits and timing
`define SCLG_MAX_BLOCKS   56
`define SCLG_MAX_CHAIN    7
`define SCLG_NUM_MARKERS  8
`define SCLG_CLK_NS       100
`define SCLG_SCAN_NS      10000
`endif

// [sclg_pkg.sv]
//=====================================================================
// sclg_pkg.sv - types of the scan-cycle logic element block
// assumes: sclg_cfg.svh is on the include path
//=====================================================================
`include "sclg_cfg.svh"
package sclg_pkg;
   // gate kinds held by an element slot
   typedef enum logic [2:0] {
      GT_AND,
      GT_AND_EDGE,
      GT_NAND,
      GT_NAND_EDGE,
      GT_OR
   } sclg_gate_t;
   // one element slot, same layout as the slot config word
   typedef struct packed {
      logic       en;     // slot holds a placed block
      logic [3:0] spare;
      sclg_gate_t gate;
      logic [7:0] src2;
      logic [7:0] src1;
      logic [7:0] src0;
   } sclg_slot_t;
   // apb request from the master
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } sclg_apb_req_t;
endpackage : sclg_pkg

// [sclg_core_props.sv]
// sclg_core_props.sv - port-level checks of the scan-cycle logic core
// assumes: apb master on the core clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module sclg_core_props
   import sclg_pkg::*;
#(
   parameter int NUM_IN  = 8,
   parameter int NUM_OUT = 4
) (
   input wire logic                    clock,
   input wire logic                    resetn,
   input wire sclg_pkg::sclg_apb_req_t apbReq,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   input wire logic [NUM_IN-1:0]       dIn,
   input wire logic [9:0]              analogChannelOne,
   input wire logic [9:0]              analogChannelTwo,
   input wire logic [NUM_OUT-1:0]      qOut,
   input wire logic                    scanStrobe
);
   //==================================================================
   // helper logic
   logic [7:0] gapCnt_r;   // clocks since last strobe, saturating
   logic [7:0] gapCnt_nxt;
   logic       mapped;     // address hits a register
   logic       inRd;       // read of the input view
   logic       anaRd;      // read of the analog latch
   // next gap count, strobe restarts it
   always_comb
   begin
      gapCnt_nxt = (gapCnt_r == 8'hff) ? gapCnt_r : gapCnt_r + 8'h01;
      if (scanStrobe)
         gapCnt_nxt = 8'h00;
   end
   // register the gap count
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         gapCnt_r <= 8'h00;
      else
         gapCnt_r <= gapCnt_nxt;
   end
   // decode: holes at 0x18 and 0x1c, nothing above the output sources
   always_comb
   begin
      mapped = (apbReq.paddr[1:0] == 2'h0) && ((apbReq.paddr <= 12'h014) ||
               ((apbReq.paddr >= 12'h020) && (apbReq.paddr <= 12'h04c)));
      inRd   = apbReq.psel && !apbReq.pwrite && (apbReq.paddr == 12'h010);
      anaRd  = apbReq.psel && !apbReq.pwrite && (apbReq.paddr == 12'h014);
   end
   //==================================================================
   // properties
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);
   property p_ready_high;
      apbReq.psel |-> pready;
   endproperty
   a_ready_high: assert property (p_ready_high)
      else $error("pready low in a transfer");
   property p_strobe_gap;
      scanStrobe |-> gapCnt_r >= 8'd99;
   endproperty
   a_strobe_gap: assert property (p_strobe_gap)
      else $error("scan strobes closer than 100 clocks");
   property p_q_hold;
      !scanStrobe |=> $stable(qOut);
   endproperty
   a_q_hold: assert property (p_q_hold)
      else $error("outputs changed between strobes");
   property p_q_reset;
      $rose(resetn) |-> qOut == '0;
   endproperty
   a_q_reset: assert property (p_q_reset)
      else $error("outputs not low after reset");
   property p_unmapped_err;
      apbReq.psel && apbReq.penable && !mapped |-> pslverr;
   endproperty
   a_unmapped_err: assert property (p_unmapped_err)
      else $error("unmapped access without error");
   property p_mapped_ok;
      apbReq.psel && apbReq.penable && mapped |-> !pslverr;
   endproperty
   a_mapped_ok: assert property (p_mapped_ok)
      else $error("error on a mapped access");
   property p_idle_data;
      !(apbReq.psel && !apbReq.pwrite && mapped) |-> prdata == 32'h0;
   endproperty
   a_idle_data: assert property (p_idle_data)
      else $error("read data not zero outside a read");
   property p_q_view;
      inRd |-> prdata[19:16] == qOut;
   endproperty
   a_q_view: assert property (p_q_view)
      else $error("input view disagrees with outputs");
   property p_mark_hold;
      inRd && !scanStrobe ##1 inRd |-> prdata[15:8] == $past(prdata[15:8]);
   endproperty
   a_mark_hold: assert property (p_mark_hold)
      else $error("markers changed without a strobe");
   property p_ana_hold;
      anaRd && !scanStrobe ##1 anaRd |-> $stable(prdata);
   endproperty
   a_ana_hold: assert property (p_ana_hold)
      else $error("analog latch changed without a strobe");
endmodule : sclg_core_props
bind sclg_core sclg_core_props #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT)) props_u (
   .clock(clock), .resetn(resetn), .apbReq(apbReq), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .dIn(dIn), .analogChannelOne(analogChannelOne),
   .analogChannelTwo(analogChannelTwo), .qOut(qOut), .scanStrobe(scanStrobe));
`default_nettype wire

// [sclg_core_tb.sv]
// sclg_core_tb.sv - self-checking bench of the scan-cycle logic core
// assumes: core answers apb itself; bench drives every pin
`timescale 1ns/1ps
`default_nettype none
module sclg_core_tb;
   import sclg_pkg::*;
   logic          clock;
   logic          resetn;
   sclg_apb_req_t apbReq;
   logic [31:0]   prdata;
   logic          pready;
   logic          pslverr;
   logic [7:0]    dIn;
   logic [9:0]    analogChannelOne;
   logic [9:0]    analogChannelTwo;
   logic [3:0]    qOut;
   logic          scanStrobe;
   integer        seed;
   int            mismatches;
   int            testsRun;
   logic [31:0]   r;
   logic          e;
   logic [2:0]    v;
   logic [3:0]    expQ;
   logic [7:0]    prev;     // last-strobe and of each slot operand set
   logic          mk;       // value marker 0 holds
   logic          bitIn;
   int            i, j, s, p;
   // slot table: gate and whether its third operand is left open
   sclg_gate_t gateTbl [8] = '{GT_AND, GT_AND_EDGE, GT_NAND, GT_NAND_EDGE,
                               GT_OR, GT_AND, GT_OR, GT_NAND_EDGE};
   logic [7:0] openTbl = 8'he0;
   int         outTbl [2][4] = '{'{0, 2, 4, 5}, '{1, 3, 6, 7}};
   sclg_core dut_u (.clock(clock), .resetn(resetn), .apbReq(apbReq), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .dIn(dIn), .analogChannelOne(analogChannelOne),
      .analogChannelTwo(analogChannelTwo), .qOut(qOut), .scanStrobe(scanStrobe));
   initial clock = 1'b0;
   always #50 clock = ~clock;
   //==================================================================
   // checks and bus tasks
   task automatic chkW(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chkW
   task automatic chkQ(input logic [3:0] got, input logic [3:0] exp);
      testsRun++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] t=%0t q=%h exp=%h", $time, got, exp);
      end
   endtask : chkQ
   // one transfer; request held until pready seen at an edge
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge clock);
      apbReq <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
      @(posedge clock);
      apbReq.penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      r = prdata;
      e = pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
   endtask : apb
   // waits past the next strobe edge, then lets it settle
   task automatic scan();
      do @(negedge clock); while (scanStrobe !== 1'b1);
      @(posedge clock);
      #1;
   endtask : scan
   task automatic place(input int k, input logic [7:0] s0, input sclg_gate_t g,
                        input logic [7:0] s2);
      apb(12'h008, 1'b1, 32'(k));
      apb(12'h00c, 1'b1, 32'(sclg_slot_t'{en:1'b1, spare:4'h0, gate:g, src2:s2,
                                          src1:8'h03, src0:s0}));
   endtask : place
   // operands with the open position defaulted per gate
   function automatic logic [2:0] opnd(input int k, input logic [2:0] x);
      opnd = x;
      if (openTbl[k])
         opnd[2] = (gateTbl[k] != GT_OR);
   endfunction : opnd
   function automatic logic gateExp(input int k, input logic [2:0] x, input logic pa);
      logic [2:0] o;
      o = opnd(k, x);
      case (gateTbl[k])
         GT_AND:       gateExp = &o;
         GT_AND_EDGE:  gateExp = &o & ~pa;
         GT_NAND:      gateExp = ~&o;
         GT_NAND_EDGE: gateExp = ~&o & pa;
         default:      gateExp = |o;
      endcase
   endfunction : gateExp
   task automatic finalReport();
      $display("checks %0d mismatches %0d", testsRun, mismatches);
      if (mismatches == 0 && testsRun > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finalReport
   // watchdog: whole run is a few thousand clocks
   initial
   begin
      repeat (20000) @(posedge clock);
      mismatches++;
      finalReport();
   end
   //==================================================================
   // main sequence
   initial
   begin
      seed = 32'haeea;
      mismatches = 0;
      testsRun = 0;
      resetn = 1'b0;
      apbReq = '0;
      dIn = 8'h00;
      analogChannelOne = 10'h000;
      analogChannelTwo = 10'h000;
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      // startup flag, constants and marker lag on the outputs
      apb(12'h040, 1'b1, 32'h17);
      apb(12'h044, 1'b1, 32'h01);
      apb(12'h048, 1'b1, 32'h00);
      apb(12'h04c, 1'b1, 32'h10);
      apb(12'h020, 1'b1, 32'h02);
      apb(12'h004, 1'b0, 32'h0);
      chkW(r & 32'h8, 32'h8);
      apb(12'h000, 1'b1, 32'h1);
      mk = 1'b0;
      for (i = 1; i <= 6; i++)
      begin
         bitIn = 1'($random(seed));
         @(posedge clock);
         dIn <= {7'h00, bitIn};
         scan();
         chkQ(qOut, {mk, 1'b0, 1'b1, (i == 1 || i >= 4)});
         mk = bitIn;
         if (i == 2)
            apb(12'h03c, 1'b1, 32'h01);
      end
      $display("startup test done");
      // gate truth tables, edges and open defaults
      for (i = 0; i < 8; i++)
         place(i, 8'h02, gateTbl[i], openTbl[i] ? 8'hff : 8'h04);
      for (p = 0; p < 2; p++)
      begin
         for (j = 0; j < 4; j++)
            apb(12'h040 + 12'(4 * j), 1'b1, 32'h40 + 32'(outTbl[p][j]));
         for (s = 0; s < 13; s++)
         begin
            v = (s >= 1 && s <= 8) ? 3'(s - 1) : 3'($random(seed));
            @(posedge clock);
            dIn <= {5'($random(seed)), v};
            scan();
            for (j = 0; j < 4; j++)
               expQ[j] = gateExp(outTbl[p][j], v, prev[outTbl[p][j]]);
            if (s > 0)
               chkQ(qOut, expQ);
            for (i = 0; i < 8; i++)
               prev[i] = &opnd(i, v);
         end
         $display("gate pass %0d done", p);
      end
      // chain depth, marker restart, order error, block count
      for (i = 0; i < 8; i++)
         place(8 + i, (i == 0) ? 8'h02 : 8'h47 + 8'(i), GT_AND, 8'hff);
      apb(12'h004, 1'b0, 32'h0);
      chkW(r & 32'h7f02, (32'd15 << 8) | 32'h2);
      apb(12'h004, 1'b1, 32'h7);
      place(15, 8'h10, GT_AND, 8'hff);
      apb(12'h004, 1'b0, 32'h0);
      chkW(r & 32'h7f02, 32'd16 << 8);
      place(16, 8'h51, GT_AND, 8'hff);
      apb(12'h004, 1'b0, 32'h0);
      chkW(r & 32'h4, 32'h4);
      apb(12'h004, 1'b1, 32'h7);
      for (i = 16; i < 56; i++)
         place(i, 8'h02, GT_OR, 8'hff);
      apb(12'h004, 1'b0, 32'h0);
      chkW(r & 32'h7f00, 32'd56 << 8);
      apb(12'h00c, 1'b1, 32'h0);
      apb(12'h004, 1'b0, 32'h0);
      chkW(r & 32'h7f00, 32'd55 << 8);
      $display("placement test done");
      // dual-purpose pins and analog latch
      @(posedge clock);
      dIn <= 8'hc0;
      analogChannelOne <= 10'($random(seed));
      analogChannelTwo <= 10'($random(seed));
      scan();
      repeat (4) @(posedge clock);
      apb(12'h010, 1'b0, 32'h0);
      chkW(r & 32'hc0, 32'hc0);
      apb(12'h000, 1'b1, 32'h7);
      apb(12'h010, 1'b0, 32'h0);
      chkW(r & 32'hc0, 32'h0);
      scan();
      apb(12'h014, 1'b0, 32'h0);
      chkW(r & 32'hfffff, {12'h000, analogChannelTwo, analogChannelOne});
      // unmapped place refuses, control word kept
      apb(12'h018, 1'b1, 32'hffffffff);
      chkW({r[31:1], e}, 32'h1);
      apb(12'h01c, 1'b0, 32'h0);
      chkW({r[31:1], e}, 32'h1);
      apb(12'h000, 1'b0, 32'h0);
      chkW(r & 32'h7, 32'h7);
      $display("register test done");
      finalReport();
   end
endmodule : sclg_core_tb
`default_nettype wire
